// >>> pkg/readout_cfg.svh
// Constants for the converter readout serial port.
// Assumes inclusion by bare name from the design file.
`ifndef READOUT_CFG_SVH
`define READOUT_CFG_SVH

// ----------------------------------------
// Conversion, stream and reset pattern settings
// ----------------------------------------
`define MODE_CONT     3'h0
`define MODE_FIR      3'h1
`define MODE_SINGLE   3'h4
`define STREAM_ON     2'h1
`define EXIT_CODE     8'hA5
`define CRC_SEED      8'hA5
`define CRC_POLY      8'h07
`define ONES_FULL     6'h3F
`define PATTERN_LAST  2'h2

// ----------------------------------------
// Serial frame counts
// ----------------------------------------
`define INSTR_LAST    7'h0F
`define EXIT_LAST     7'h07
`define LEN_SHORT     7'h10
`define LEN_FULL      7'h18
`define LEN_FLAGS     7'h20
`define LEN_STREAM_X  7'h28
`define LEN_NONE      7'h08

// ----------------------------------------
// Result view addresses and read tags
// ----------------------------------------
`define ADDR_CH_BASE  14'h0010
`define ADDR_FULL     14'h0020
`define ADDR_FULL_ST  14'h0021
`define ADDR_SHORT    14'h0022
`define ADDR_SHORT_ST 14'h0023
`define TAG_SHARED    3'h4
`define TAG_NONE      3'h7

`endif

// >>> pkg/readout_pkg.sv
// Types shared by the readout serial port.
// Assumes the constants header is on the include path.
package readout_pkg;

  // Serial port state
  typedef enum logic [2:0] {
    LK_IDLE   = 3'h0,
    LK_INSTR  = 3'h1,
    LK_READ   = 3'h2,
    LK_WRITE  = 3'h3,
    LK_STREAM = 3'h4,
    LK_DONE   = 3'h5
  } link_state_type;

  // Conversion sequencer state
  typedef enum logic [1:0] {
    SQ_STANDBY = 2'h0,
    SQ_START   = 2'h1,
    SQ_WAIT    = 2'h2
  } seq_state_type;

endpackage : readout_pkg

// >>> logic/adc_readout_port.sv
// Serial host port, channel sequencer and result registers of the converter.
// Assumes config ports come from logic on CORE_CLK and the host is the serial master.
`timescale 1ns/10ps
`include "readout_cfg.svh"
module adc_readout_port (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic        CE,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        SDI,
  output logic             SDO_OUT,
  output logic             SDO_OE_N,
  output logic             AUX_DIGITAL_PIN_ONE_N,
  input  wire logic [2:0]  CONV_MODE,
  input  wire logic        SHARED_SEL,
  input  wire logic [3:0]  CHAN_EN,
  input  wire logic [15:0] CHAN_REPEAT,
  input  wire logic [1:0]  STREAM_READOUT_SELECT,
  input  wire logic        STREAM_APPEND_ENABLE,
  input  wire logic        READY_ON_AUX,
  output logic             CONV_START,
  output logic [1:0]       CONV_CHAN,
  output logic             CONV_FIR,
  input  wire logic        CONV_DONE,
  input  wire logic [23:0] CONV_DATA,
  output logic             READY_STATUS_BIT,
  output logic             STREAM_ACTIVE,
  output logic             STREAM_EXIT,
  output logic             SW_RESET,
  output logic             REG_WR_STB,
  output logic [13:0]      REG_WR_ADDR,
  output logic [7:0]       REG_WR_DATA
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Lowest enabled channel at or above lo; msb flags a hit
  function automatic logic [2:0] next_ch(input logic [3:0] en, input logic [2:0] lo);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--)
      if (en[i] && (3'(i) >= lo))
        r = {1'b1, 2'(i)};
    return r;
  endfunction : next_ch

  // Repeat count of a channel, shared mode only
  function automatic logic [3:0] rep_of(input logic [15:0] reps, input logic sh, input logic [1:0] c);
    rep_of = sh ? reps[{c, 2'h0} +: 4] : 4'h0;
  endfunction : rep_of

  // Check byte over result and status, msb first
  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = `CRC_SEED;
    for (int i = 31; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `CRC_POLY : 8'h00);
    return c;
  endfunction : crc8

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic                       rst;
  logic                       sw_rst_r;
  logic [5:0]                 c_s1, c_s2, c_s3, c_acc, c_prev;
  logic [3:0]                 l_s1, l_s2, l_s3, l_acc;
  logic                       busy_r, rd_tog_r, wr_tog_r, exit_tog_r, swr_tog_r;
  logic                       link_rst_r, abort_tog_r, res_tog_r, frm_tog_r;
  logic                       stream_on_r, exit_r, ready_r, app_r;
  logic                       rd_ev, wr_ev, exit_ev, swr_ev, cs_rise;
  logic                       busy_eff, hold, cnv_ok, run_ok;
  readout_pkg::seq_state_type sq_r;
  logic [1:0]                 ch_r;
  logic [3:0]                 rep_r;
  logic                       single_done_r, seq_end_r, start_r;
  logic [2:0]                 mode_q_r, low, nxt;
  logic [23:0]                shared_r;
  logic [7:0]                 status_r, crc_r;
  logic [23:0]                ch_res_r [0:3];
  logic [3:0]                 mask_r, mask_nxt;
  logic                       ready_nxt;
  readout_pkg::link_state_type lk_r;
  logic [6:0]                 cnt_r, len_r, rd_len;
  logic [15:0]                in_sr_r;
  logic [39:0]                out_sr_r, rd_word;
  logic [13:0]                addr_r, wr_addr_r, cur_addr;
  logic [7:0]                 wr_data_r;
  logic [2:0]                 rd_id_r, rd_id;
  logic [5:0]                 ones_r;
  logic [1:0]                 pat_r;
  logic                       frm_seen_r, served_r, drv_r, sdo_r, ab_prev_r;
  logic                       frame_new, lrst;
  readout_pkg::link_state_type lk_cur;
  logic [6:0]                 cnt_cur;

  assign rst = !RSTN || sw_rst_r;

  // ----------------------------------------
  // Crossings into the core clock
  // ----------------------------------------
  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      c_s1   <= 6'h20;
      c_s2   <= 6'h20;
      c_s3   <= 6'h20;
      c_acc  <= 6'h20;
      c_prev <= 6'h20;
    end
    else
    begin
      c_s1   <= {CS_N, busy_r, rd_tog_r, wr_tog_r, exit_tog_r, swr_tog_r};
      c_s2   <= c_s1;
      c_s3   <= c_s2;
      c_acc  <= (c_s2 & c_s3) | (c_acc & (c_s2 | c_s3));
      c_prev <= c_acc;
    end
  end

  assign cs_rise  = c_acc[5] && !c_prev[5];
  assign rd_ev    = c_acc[3] != c_prev[3];
  assign wr_ev    = c_acc[2] != c_prev[2];
  assign exit_ev  = c_acc[1] != c_prev[1];
  assign swr_ev   = c_acc[0] != c_prev[0];
  assign busy_eff = c_acc[4] && !c_acc[5];

  // ----------------------------------------
  // Port mode, exit and software reset
  // ----------------------------------------
  // Software reset restores core state next cycle, except the crossing stages, which only RSTN clears
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
      sw_rst_r <= 1'b0;
    else
      sw_rst_r <= swr_ev && !sw_rst_r;
  end

  // Stream readout needs the shared register; exit holds until field leaves
  always_ff @(posedge CORE_CLK)
  begin
    if (rst)
    begin
      stream_on_r <= 1'b0;
      exit_r      <= 1'b0;
      STREAM_EXIT <= 1'b0;
      app_r       <= 1'b0;
      link_rst_r  <= 1'b1;
      frm_tog_r   <= 1'b0;
    end
    else if (CE)
    begin
      link_rst_r  <= 1'b0;
      STREAM_EXIT <= exit_ev && stream_on_r;
      if (STREAM_READOUT_SELECT != `STREAM_ON)
        exit_r <= 1'b0;
      else if (exit_ev)
        exit_r <= 1'b1;
      stream_on_r <= (STREAM_READOUT_SELECT == `STREAM_ON) && SHARED_SEL && !exit_r && !exit_ev;
      if (!stream_on_r)
        app_r <= STREAM_APPEND_ENABLE;
      if (cs_rise)
        frm_tog_r <= !frm_tog_r;
    end
  end

  assign STREAM_ACTIVE = stream_on_r;
  assign SW_RESET      = sw_rst_r;

  // ----------------------------------------
  // Channel sequencer
  // ----------------------------------------
  assign low    = next_ch(CHAN_EN, 3'h0);
  assign nxt    = next_ch(CHAN_EN, {1'b0, ch_r} + 3'h1);
  assign run_ok = low[2] && ((CONV_MODE == `MODE_CONT) || (CONV_MODE == `MODE_FIR) ||
                  ((CONV_MODE == `MODE_SINGLE) && !single_done_r));
  assign cnv_ok = CONV_DONE && (sq_r == readout_pkg::SQ_WAIT);

  // Walks enabled channels low to high, only the lowest in FIR mode, with repeats in shared mode
  always_ff @(posedge CORE_CLK)
  begin
    if (rst)
    begin
      sq_r          <= readout_pkg::SQ_STANDBY;
      ch_r          <= 2'h0;
      rep_r         <= 4'h0;
      single_done_r <= 1'b0;
      seq_end_r     <= 1'b0;
      start_r       <= 1'b0;
      mode_q_r      <= `MODE_CONT;
    end
    else if (CE)
    begin
      start_r   <= 1'b0;
      seq_end_r <= 1'b0;
      mode_q_r  <= CONV_MODE;
      if (CONV_MODE != mode_q_r)
      begin
        single_done_r <= 1'b0;
        sq_r          <= readout_pkg::SQ_STANDBY;
      end
      else
      begin
        unique case (sq_r)
          readout_pkg::SQ_STANDBY:
            if (run_ok)
            begin
              ch_r  <= low[1:0];
              rep_r <= rep_of(CHAN_REPEAT, SHARED_SEL && (CONV_MODE != `MODE_FIR), low[1:0]);
              sq_r  <= readout_pkg::SQ_START;
            end
          readout_pkg::SQ_START:
          begin
            start_r <= 1'b1;
            sq_r    <= readout_pkg::SQ_WAIT;
          end
          readout_pkg::SQ_WAIT:
            if (CONV_DONE)
            begin
              if (CONV_MODE == `MODE_FIR)
              begin
                seq_end_r <= 1'b1;
                sq_r      <= readout_pkg::SQ_STANDBY;
              end
              else if (rep_r != 4'h0)
              begin
                rep_r <= rep_r - 4'h1;
                sq_r  <= readout_pkg::SQ_START;
              end
              else if (nxt[2])
              begin
                ch_r  <= nxt[1:0];
                rep_r <= rep_of(CHAN_REPEAT, SHARED_SEL, nxt[1:0]);
                sq_r  <= readout_pkg::SQ_START;
              end
              else
              begin
                seq_end_r <= 1'b1;
                if (CONV_MODE == `MODE_SINGLE)
                  single_done_r <= 1'b1;
                sq_r <= readout_pkg::SQ_STANDBY;
              end
            end
          default:
            sq_r <= readout_pkg::SQ_STANDBY;
        endcase
      end
    end
  end

  assign CONV_START = start_r;
  assign CONV_CHAN  = ch_r;
  assign CONV_FIR   = (CONV_MODE == `MODE_FIR);

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  // A register under access keeps its word unless a stream read is overrun
  assign hold = busy_eff && !stream_on_r;

  always_ff @(posedge CORE_CLK)
  begin
    if (rst)
    begin
      shared_r    <= 24'h000000;
      status_r    <= 8'h00;
      crc_r       <= 8'h00;
      res_tog_r   <= 1'b0;
      abort_tog_r <= 1'b0;
      for (int i = 0; i < 4; i++)
        ch_res_r[i] <= 24'h000000;
    end
    else if (CE && cnv_ok && !hold)
    begin
      if (SHARED_SEL)
      begin
        shared_r  <= CONV_DATA;
        status_r  <= {6'h00, ch_r};
        crc_r     <= crc8({CONV_DATA, 6'h00, ch_r});
        res_tog_r <= !res_tog_r;
        if (stream_on_r && busy_eff)
          abort_tog_r <= !abort_tog_r;
      end
      else
        ch_res_r[ch_r] <= CONV_DATA;
    end
  end

  // Ready flag; a new result wins over a read in the same cycle
  always_comb
  begin
    ready_nxt = ready_r;
    mask_nxt  = mask_r;
    if (rd_ev && (rd_id_r == `TAG_SHARED) && SHARED_SEL)
      ready_nxt = 1'b1;
    if (rd_ev && !rd_id_r[2] && !SHARED_SEL)
    begin
      mask_nxt = mask_r | (4'h1 << rd_id_r[1:0]);
      if ((mask_nxt & CHAN_EN) == CHAN_EN)
        ready_nxt = 1'b1;
    end
    if (SHARED_SEL && cnv_ok && !hold)
      ready_nxt = 1'b0;
    if (!SHARED_SEL && seq_end_r)
    begin
      ready_nxt = 1'b0;
      mask_nxt  = 4'h0;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (rst)
    begin
      ready_r               <= 1'b1;
      mask_r                <= 4'h0;
      AUX_DIGITAL_PIN_ONE_N <= 1'b1;
    end
    else if (CE)
    begin
      ready_r               <= ready_nxt;
      mask_r                <= mask_nxt;
      AUX_DIGITAL_PIN_ONE_N <= !READY_ON_AUX || ready_nxt;
    end
  end

  assign READY_STATUS_BIT = ready_r;

  // Register writes handed to the map outside
  always_ff @(posedge CORE_CLK)
  begin
    if (rst)
    begin
      REG_WR_STB  <= 1'b0;
      REG_WR_ADDR <= 14'h0000;
      REG_WR_DATA <= 8'h00;
    end
    else if (CE)
    begin
      REG_WR_STB <= wr_ev;
      if (wr_ev)
      begin
        REG_WR_ADDR <= wr_addr_r;
        REG_WR_DATA <= wr_data_r;
      end
    end
  end

  // ----------------------------------------
  // Serial clock side
  // ----------------------------------------
  // Crossing of core levels into the serial clock
  always_ff @(posedge SCLK)
  begin
    l_s1  <= {link_rst_r, stream_on_r, abort_tog_r, app_r};
    l_s2  <= l_s1;
    l_s3  <= l_s2;
    l_acc <= (l_s2 & l_s3) | (l_acc & (l_s2 | l_s3));
  end

  assign lrst      = l_acc[3];
  assign frame_new = frm_tog_r != frm_seen_r;
  assign lk_cur    = frame_new ? readout_pkg::LK_IDLE : lk_r;
  assign cnt_cur   = frame_new ? 7'h00 : cnt_r;
  assign cur_addr  = {in_sr_r[12:0], SDI};

  // Word, length and tag of a register read
  always_comb
  begin
    rd_word = 40'h0000000000;
    rd_len  = `LEN_NONE;
    rd_id   = `TAG_NONE;
    if (cur_addr == `ADDR_FULL)
    begin
      rd_word = {shared_r, 16'h0000};
      rd_len  = `LEN_FULL;
      rd_id   = `TAG_SHARED;
    end
    else if (cur_addr == `ADDR_FULL_ST)
    begin
      rd_word = {shared_r, ready_r, status_r[6:0], 8'h00};
      rd_len  = `LEN_FLAGS;
      rd_id   = `TAG_SHARED;
    end
    else if (cur_addr == `ADDR_SHORT)
    begin
      rd_word = {shared_r[23:8], 24'h000000};
      rd_len  = `LEN_SHORT;
      rd_id   = `TAG_SHARED;
    end
    else if (cur_addr == `ADDR_SHORT_ST)
    begin
      rd_word = {shared_r[23:8], ready_r, status_r[6:0], 16'h0000};
      rd_len  = `LEN_FULL;
      rd_id   = `TAG_SHARED;
    end
    else if (cur_addr[13:2] == 12'(`ADDR_CH_BASE >> 2))
    begin
      rd_word = {ch_res_r[cur_addr[1:0]], 16'h0000};
      rd_len  = `LEN_FULL;
      rd_id   = {1'b0, cur_addr[1:0]};
    end
  end

  // Frame engine; samples on the rising edge
  always_ff @(posedge SCLK)
  begin
    if (lrst)
    begin
      lk_r <= readout_pkg::LK_IDLE;
      cnt_r <= 7'h00;
      frm_seen_r <= 1'b0;
      served_r <= 1'b0;
      drv_r <= 1'b0;
      busy_r <= 1'b0;
      rd_tog_r <= 1'b0;
      wr_tog_r <= 1'b0;
      exit_tog_r <= 1'b0;
      ab_prev_r <= 1'b0;
      in_sr_r <= 16'h0000;
      out_sr_r <= 40'h0000000000;
      len_r <= 7'h00;
      addr_r <= 14'h0000;
      rd_id_r <= `TAG_NONE;
      wr_addr_r <= 14'h0000;
      wr_data_r <= 8'h00;
    end
    else
    begin
      frm_seen_r <= frm_tog_r;
      ab_prev_r  <= l_acc[1];
      in_sr_r    <= {in_sr_r[14:0], SDI};
      cnt_r      <= cnt_cur + 7'h01;
      unique case (lk_cur)
        readout_pkg::LK_IDLE:
          if (l_acc[2] && !ready_r)
          begin
            lk_r     <= readout_pkg::LK_STREAM;
            served_r <= res_tog_r;
            rd_id_r  <= `TAG_SHARED;
            busy_r   <= 1'b1;
            drv_r    <= 1'b1;
            len_r    <= l_acc[0] ? `LEN_STREAM_X : `LEN_FULL;
            out_sr_r <= {shared_r[22:0], status_r, crc_r, 1'b0};
          end
          else if (!l_acc[2] && !SDI)
          begin
            lk_r   <= readout_pkg::LK_INSTR;
            busy_r <= 1'b1;
          end
          else
            cnt_r <= 7'h00;
        readout_pkg::LK_INSTR:
          if (cnt_cur == `INSTR_LAST)
          begin
            addr_r <= cur_addr;
            if (in_sr_r[13])
            begin
              lk_r     <= readout_pkg::LK_READ;
              out_sr_r <= rd_word;
              len_r    <= rd_len;
              rd_id_r  <= rd_id;
              drv_r    <= 1'b1;
            end
            else
            begin
              lk_r   <= readout_pkg::LK_WRITE;
              busy_r <= 1'b0;
            end
          end
        readout_pkg::LK_READ:
          if (cnt_cur == `INSTR_LAST + len_r)
          begin
            lk_r     <= readout_pkg::LK_DONE;
            rd_tog_r <= !rd_tog_r;
            busy_r   <= 1'b0;
            drv_r    <= 1'b0;
          end
          else
            out_sr_r <= {out_sr_r[38:0], 1'b0};
        readout_pkg::LK_WRITE:
          if (cnt_cur[2:0] == 3'h7)
          begin
            wr_data_r <= {in_sr_r[6:0], SDI};
            wr_addr_r <= addr_r;
            addr_r    <= addr_r + 14'h0001;
            wr_tog_r  <= !wr_tog_r;
          end
        readout_pkg::LK_STREAM:
        begin
          if ((cnt_cur == `EXIT_LAST) && ({in_sr_r[6:0], SDI} == `EXIT_CODE))
            exit_tog_r <= !exit_tog_r;
          if (l_acc[1] != ab_prev_r)
          begin
            lk_r   <= readout_pkg::LK_DONE;
            busy_r <= 1'b0;
            drv_r  <= 1'b0;
          end
          else if (cnt_cur == len_r - 7'h01)
          begin
            lk_r     <= readout_pkg::LK_DONE;
            rd_tog_r <= !rd_tog_r;
            busy_r   <= 1'b0;
            drv_r    <= 1'b0;
          end
          else
            out_sr_r <= {out_sr_r[38:0], 1'b0};
        end
        readout_pkg::LK_DONE:
        begin
          cnt_r <= 7'h00;
          if (l_acc[2] && (res_tog_r != served_r))
            lk_r <= readout_pkg::LK_IDLE;
        end
        default:
          lk_r <= readout_pkg::LK_IDLE;
      endcase
    end
  end

  // Reset pattern watcher, independent of frames
  always_ff @(posedge SCLK)
  begin
    if (lrst)
    begin
      ones_r    <= 6'h00;
      pat_r     <= 2'h0;
      swr_tog_r <= 1'b0;
    end
    else if (SDI)
      ones_r <= (ones_r == `ONES_FULL) ? ones_r : ones_r + 6'h01;
    else
    begin
      ones_r <= 6'h00;
      if (ones_r != `ONES_FULL)
        pat_r <= 2'h0;
      else if (pat_r == `PATTERN_LAST)
      begin
        pat_r     <= 2'h0;
        swr_tog_r <= !swr_tog_r;
      end
      else
        pat_r <= pat_r + 2'h1;
    end
  end

  // Output bit changes on the falling edge
  always_ff @(negedge SCLK)
  begin
    if (lrst)
      sdo_r <= 1'b0;
    else if (drv_r)
      sdo_r <= out_sr_r[39];
  end

  // Pin drive: released while select is high
  assign SDO_OE_N = CS_N;
  assign SDO_OUT  = drv_r ? sdo_r :
                    (stream_on_r && !ready_r) ? shared_r[23] :
                    READY_ON_AUX ? sdo_r : ready_r;

endmodule : adc_readout_port

// >>> dv/adc_readout_port_asserts.sv
// Pin-level checks on the readout port.
// Assumes it is bound onto adc_readout_port, one CORE_CLK domain.
`timescale 1ns/10ps
module adc_readout_port_asserts (
  input wire logic       CORE_CLK,
  input wire logic       RSTN,
  input wire logic       CS_N,
  input wire logic       SDO_OE_N,
  input wire logic       AUX_DIGITAL_PIN_ONE_N,
  input wire logic       READY_ON_AUX,
  input wire logic [2:0] CONV_MODE,
  input wire logic       CONV_START,
  input wire logic [1:0] CONV_CHAN,
  input wire logic       CONV_FIR,
  input wire logic       READY_STATUS_BIT,
  input wire logic       STREAM_ACTIVE,
  input wire logic [1:0] STREAM_READOUT_SELECT,
  input wire logic       STREAM_EXIT,
  input wire logic       SW_RESET,
  input wire logic       REG_WR_STB
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  a_oe_follows_cs: assert property (SDO_OE_N == CS_N) else $error("sdo enable differs from select");
  a_fir_flag: assert property (CONV_FIR == (CONV_MODE == 3'h1)) else $error("fir flag wrong");
  a_aux_idle: assert property (!READY_ON_AUX |=> AUX_DIGITAL_PIN_ONE_N) else $error("aux pin not idle");
  a_start_gap: assert property (CONV_START |=> !CONV_START [*2]) else $error("starts too close");
  a_wr_blocked: assert property (STREAM_ACTIVE && $past(STREAM_ACTIVE) |-> !REG_WR_STB)
    else $error("write during stream");
  a_stream_sel: assert property ($rose(STREAM_ACTIVE) |-> STREAM_READOUT_SELECT == 2'h1)
    else $error("stream without select");
  a_exit_in_stream: assert property (STREAM_EXIT |-> $past(STREAM_ACTIVE)) else $error("exit outside stream");
  a_sw_reset_clears: assert property (SW_RESET |-> ##[1:2] (READY_STATUS_BIT && !STREAM_ACTIVE))
    else $error("soft reset left state");
  c_exit: cover property (STREAM_EXIT);
  c_soft_reset: cover property (SW_RESET);
  c_third_chan: cover property (CONV_START && CONV_CHAN == 2'h2);
endmodule : adc_readout_port_asserts

bind adc_readout_port adc_readout_port_asserts adc_readout_port_asserts_inst (.CORE_CLK, .RSTN, .CS_N,
  .SDO_OE_N, .AUX_DIGITAL_PIN_ONE_N, .READY_ON_AUX, .CONV_MODE, .CONV_START, .CONV_CHAN, .CONV_FIR,
  .READY_STATUS_BIT, .STREAM_ACTIVE, .STREAM_READOUT_SELECT, .STREAM_EXIT, .SW_RESET, .REG_WR_STB);

// >>> dv/spi_host_model.sv
// Serial master model; serial clock idles low and runs in frames and in idle_clocks with select high.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
module spi_host_model (
  output logic      SCLK,
  output logic      CS_N,
  output logic      SDI,
  input  wire logic SDO_OUT
);
  initial
  begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SDI = 1'b1;
  end
  // Select control
  task automatic sel(input logic v);
    CS_N = v;
    #40;
  endtask : sel
  // Shift n bits, top bit first, data changed on fall, sampled on rise
  task automatic shift(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      SDI = tx[i];
      #32 SCLK = 1'b1;
      rx[i] = SDO_OUT;
      #32 SCLK = 1'b0;
    end
  endtask : shift
  // One framed transfer, select released with idle data high
  task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
    sel(1'b0);
    shift(n, tx, rx);
    SDI = 1'b1;
    sel(1'b1);
    #200;
  endtask : frame
  // Clocks with select high
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      #32 SCLK = 1'b1;
      #32 SCLK = 1'b0;
    end
  endtask : idle_clocks
endmodule : spi_host_model

// >>> dv/adc_readout_port_tb_top.sv
// Bench for the readout port: host model on the link, converter stand-in.
// Assumes the host model and checker are compiled first.
`timescale 1ns/10ps
module adc_readout_port_tb_top;
  logic CORE_CLK, RSTN, SCLK, CS_N, SDI, SDO_OUT, SDO_OE_N, AUX_DIGITAL_PIN_ONE_N, SHARED_SEL, READY_ON_AUX;
  logic CONV_START, CONV_FIR, READY_STATUS_BIT, STREAM_ACTIVE, STREAM_EXIT, SW_RESET, REG_WR_STB;
  logic [1:0] CONV_CHAN, STREAM_READOUT_SELECT;
  logic [3:0] CHAN_EN;
  logic [15:0] CHAN_REPEAT;
  logic [13:0] REG_WR_ADDR;
  logic [7:0] REG_WR_DATA;
  logic [23:0] CONV_DATA = 24'h0;
  logic CE = 1'b1, STREAM_APPEND_ENABLE = 1'b0;
  logic [2:0] CONV_MODE = 3'h0;
  logic [63:0] rx;
  logic CONV_DONE = 1'b0, pend = 1'b0, exit_seen = 1'b0, swr_seen = 1'b0;
  logic [21:0] wr_seen;
  logic [1:0] log_q[$];
  int allow = 0, err_count = 0, n_tests = 0, k;

  adc_readout_port adc_readout_port_inst (.CORE_CLK, .RSTN, .CE, .SCLK, .CS_N, .SDI, .SDO_OUT, .SDO_OE_N,
    .AUX_DIGITAL_PIN_ONE_N, .CONV_MODE, .SHARED_SEL, .CHAN_EN, .CHAN_REPEAT, .STREAM_READOUT_SELECT,
    .STREAM_APPEND_ENABLE, .READY_ON_AUX, .CONV_START, .CONV_CHAN, .CONV_FIR, .CONV_DONE, .CONV_DATA,
    .READY_STATUS_BIT, .STREAM_ACTIVE, .STREAM_EXIT, .SW_RESET, .REG_WR_STB, .REG_WR_ADDR, .REG_WR_DATA);
  spi_host_model host (.SCLK, .CS_N, .SDI, .SDO_OUT);

  // Core clock
  initial
  begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end
  // Converter stand-in: ends a start only while allowed; pulse catchers
  always @(negedge CORE_CLK)
  begin
    CONV_DONE = 1'b0;
    if (CONV_START)
    begin
      pend = 1'b1;
      log_q.push_back(CONV_CHAN);
    end
    else if (pend && allow > 0)
    begin
      CONV_DONE = 1'b1;
      CONV_DATA = {16'hC35A, 6'h00, CONV_CHAN};
      pend = 1'b0;
      allow--;
    end
    if (STREAM_EXIT) exit_seen = 1'b1;
    if (SW_RESET) swr_seen = 1'b1;
    if (REG_WR_STB) wr_seen = {REG_WR_ADDR, REG_WR_DATA};
  end

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One bounded wait step
  task automatic tick;
    @(negedge CORE_CLK);
    k++;
    if (k > 6000)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask : tick
  task automatic wait_ready(input logic lvl);
    k = 0;
    while (READY_STATUS_BIT !== lvl) tick();
  endtask : wait_ready
  task automatic do_reset;
    RSTN = 1'b0;
    repeat (16) @(negedge CORE_CLK);
    host.idle_clocks(6);
    @(negedge CORE_CLK);
    check("reset stream", STREAM_ACTIVE, 1'b0);
    RSTN = 1'b1;
    pend = 1'b0;
    log_q.delete();
    repeat (2) @(negedge CORE_CLK);
    host.idle_clocks(6);
    check("reset ready", READY_STATUS_BIT, 1'b1);
    check("stream after reset", STREAM_ACTIVE, STREAM_READOUT_SELECT == 2'h1 && SHARED_SEL);
  endtask : do_reset

  task automatic t_perchan;
    allow = 1;
    repeat (30) @(negedge CORE_CLK);
    check("ready one of two", READY_STATUS_BIT, 1'b1);
    allow = 1;
    wait_ready(1'b0);
    repeat (2) @(negedge CORE_CLK);
    check("aux ready", AUX_DIGITAL_PIN_ONE_N, 1'b0);
    host.frame(40, {2'b01, 14'h0010, 24'h0}, rx);
    check("chan0", rx[23:0], 24'hC35A00);
    check("ready half read", READY_STATUS_BIT, 1'b0);
    host.frame(40, {2'b01, 14'h0011, 24'h0}, rx);
    check("chan1", rx[23:0], 24'hC35A01);
    wait_ready(1'b1);
  endtask : t_perchan
  task automatic t_shared;
    allow = 1;
    wait_ready(1'b0);
    host.frame(48, {2'b01, 14'h0021, 32'h0}, rx);
    check("full status", rx[31:0], 32'hC35A0101);
    wait_ready(1'b1);
    host.frame(40, {2'b01, 14'h0020, 24'h0}, rx);
    check("full", rx[23:0], 24'hC35A01);
    host.frame(32, {2'b01, 14'h0022, 16'h0}, rx);
    check("short", rx[15:0], 16'hC35A);
    host.frame(40, {2'b01, 14'h0023, 24'h0}, rx);
    check("short status", rx[23:0], 24'hC35A81);
    allow = 3;
    k = 0;
    while (log_q.size() < 5) tick();
    check("order", {log_q[0], log_q[1], log_q[2], log_q[3], log_q[4]}, 10'h165);
  endtask : t_shared
  task automatic t_modes;
    CONV_MODE = 3'h1;
    allow = 2;
    log_q.delete();
    k = 0;
    while (log_q.size() < 2) tick();
    check("fir chan", {CONV_FIR, log_q[0], log_q[1]}, 5'h15);
    CONV_MODE = 3'h4;
    allow = 8;
    log_q.delete();
    repeat (80) @(negedge CORE_CLK);
    check("single pass", log_q.size(), 3);
    allow = 0;
    CONV_MODE = 3'h0;
  endtask : t_modes
  task automatic t_write;
    host.frame(24, {2'b00, 14'h0123, 8'h3C}, rx);
    check("write", wr_seen, {14'h0123, 8'h3C});
    @(negedge CORE_CLK);
  endtask : t_write
  task automatic t_stream;
    k = 0;
    while (!STREAM_ACTIVE) tick();
    host.sel(1'b0);
    allow = 1;
    wait_ready(1'b0);
    host.shift(24, {8'hA5, 16'hFFFF}, rx);
    check("stream data", rx[23:0], 24'hC35A00);
    wait_ready(1'b1);
    check("exit", exit_seen, 1'b1);
    STREAM_READOUT_SELECT = 2'h0;
    host.sel(1'b1);
  endtask : t_stream
  task automatic t_swreset;
    host.sel(1'b0);
    repeat (3) host.shift(64, 64'hFFFFFFFFFFFFFFFE, rx);
    host.sel(1'b1);
    repeat (8) @(negedge CORE_CLK);
    check("soft reset", swr_seen, 1'b1);
  endtask : t_swreset

  // Main sequence
  initial
  begin
    SHARED_SEL = 1'b0;
    CHAN_EN = 4'h3;
    CHAN_REPEAT = 16'h0000;
    STREAM_READOUT_SELECT = 2'h0;
    READY_ON_AUX = 1'b1;
    do_reset();
    t_perchan();
    SHARED_SEL = 1'b1;
    CHAN_EN = 4'h6;
    CHAN_REPEAT = 16'h0010;
    READY_ON_AUX = 1'b0;
    do_reset();
    t_shared();
    t_modes();
    t_write();
    CHAN_EN = 4'h1;
    STREAM_READOUT_SELECT = 2'h1;
    do_reset();
    t_stream();
    t_swreset();
    tally_and_finish();
  end
endmodule : adc_readout_port_tb_top
